// >>> pkg/mra_pkg.sv
// Constants and types shared by the metering register access block
package mra_pkg;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int SAMPLE_W = 24;
   localparam int NUM_PH   = 3;
   localparam int NUM_RMS  = 4;
   localparam int NUM_DEN  = 3;
   localparam int DEN_W    = 16;
   localparam int ZX_W     = 16;
   localparam int CNT_W    = 12;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_SAG    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_ZX     = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_DEN0   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_STATE  = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_RMS0   = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_STEP   = 8'h04;

   // Status, mask and state field positions
   localparam int ST_LOOP    = 0;
   localparam int ST_CORRUPT = 1;
   localparam int ST_ARMED   = 2;
   localparam int ST_W       = 3;
   localparam int SS_ARMED   = 0;
   localparam int SS_CORRUPT = 1;

   // Reset values
   localparam logic [SAMPLE_W-1:0] SAG_RST  = 24'h00_0000;
   localparam logic [ZX_W-1:0]     ZX_RST   = 16'hFFFF;
   localparam logic [DEN_W-1:0]    DEN_RST  = 16'h0000;
   localparam logic [ST_W-1:0]     MASK_RST = 3'h0;

   // Arming level in percent of full scale
   localparam int ARM_PCT = 10;

   // Timing
   localparam int CLK_PERIOD_NS  = 100;
   localparam int LOOP_PERIOD_NS = 125000;
   localparam int RMS_GAP_NS     = 265000;
   localparam int LOOP_CYCLES    = LOOP_PERIOD_NS / CLK_PERIOD_NS;
   localparam int RMS_GAP_CYCLES =
      (RMS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] LOOP_LAST = CNT_W'(LOOP_CYCLES - 1);
   localparam logic [CNT_W-1:0] RMS_GAP   = CNT_W'(RMS_GAP_CYCLES);

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } mra_req_t;

   typedef struct packed {
      logic [NUM_PH-1:0][SAMPLE_W-1:0] volt;
      logic                            valid;
   } mra_phase_t;

   typedef struct packed {
      logic [NUM_RMS-1:0][SAMPLE_W-1:0] val;
   } mra_rms_t;

   typedef struct packed {
      logic [NUM_DEN-1:0][DEN_W-1:0] den;
   } mra_den_t;
endpackage

// >>> design/mra_level_cmp.sv
// Magnitude comparator of one phase voltage sample against a level
`timescale 1ns/100ps
`default_nettype none
module mra_level_cmp
   import mra_pkg::*;
#(
   parameter int W = SAMPLE_W
)
(
   input  wire logic [W-1:0] sample,   // Signed sample
   input  wire logic [W-1:0] level,    // Unsigned level
   output logic              above     // Magnitude exceeds level
);
   logic [W:0] ext;
   logic [W:0] mag;

   always_comb
   begin
      ext = {sample[W-1], sample};
      // One extra bit so the most negative code stays positive
      mag = sample[W-1] ? (~ext + {{W{1'b0}}, 1'b1}) : ext;
      above = mag > {1'b0, level};
   end
endmodule // mra_level_cmp
`default_nettype wire

// >>> design/mra_top.sv
// Register access, threshold deferral and rms read pacing of the meter
//
// Behaviour
// - Sag threshold waits for a phase above 10%
// - Zero-cross timeout waits for phase above 10%
// - Results computed in fixed 125 us loop
// - Back-to-back rms read corrupts rms, apparent
// - Next 125 us loop recovers correct values
`timescale 1ns/100ps
`default_nettype none
module mra_top
   import mra_pkg::*;
#(
   parameter logic [SAMPLE_W-1:0] FULL_SCALE = 24'h40_0000
)
(
   input  wire logic                mclk,          // System clock
   input  wire logic                reset,         // Sync reset, high
   input  wire mra_req_t            req,           // Register request
   output logic [DATA_W-1:0]        rdData,        // Read data, next cycle
   input  wire mra_phase_t          phase,         // Phase voltage samples
   input  wire mra_rms_t            rmsIn,         // Rms results of loop
   output logic [SAMPLE_W-1:0]      sagLevelThreshold, // Applied sag level
   output logic [ZX_W-1:0]          zeroCrossTimeout,  // Applied timeout
   output mra_den_t                 pulseOutputDen,    // Denominators
   output logic                     dataReadyInterrupt, // Loop end pulse
   output logic                     apparentCorrupt,   // Loop result bad
   output logic                     firstInterruptPin  // Interrupt, high
);
   localparam logic [SAMPLE_W-1:0] ARM_LEVEL =
      SAMPLE_W'((int'(FULL_SCALE) * ARM_PCT) / 100);

   // Register state
   logic [SAMPLE_W-1:0] sagPend_q, sagPend_d;
   logic [SAMPLE_W-1:0] sagAppl_q, sagAppl_d;
   logic [ZX_W-1:0]     zxPend_q, zxPend_d;
   logic [ZX_W-1:0]     zxAppl_q, zxAppl_d;
   mra_den_t            den_q, den_d;
   logic [ST_W-1:0]     status_q, status_d;
   logic [ST_W-1:0]     mask_q, mask_d;
   logic                armed_q, armed_d;
   // Loop and pacing state
   logic [CNT_W-1:0]    loopCnt_q, loopCnt_d;
   logic [CNT_W-1:0]    rmsGap_q, rmsGap_d;
   logic                corrupt_q, corrupt_d;
   logic                tick_q, tick_d;
   mra_rms_t            rms_q, rms_d;
   logic [DATA_W-1:0]   rdData_q, rdData_d;

   logic [NUM_PH-1:0]   phAbove;
   logic                armEvent;
   logic                loopEnd;
   logic                rmsHit;
   logic                rmsTooSoon;
   logic [ST_W-1:0]     events;
   logic [ST_W-1:0]     w1c;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PH; gi++)
      begin : g_cmp
         mra_level_cmp #(
            .W      (SAMPLE_W)
         ) u_cmp (
            .sample (phase.volt[gi]),
            .level  (ARM_LEVEL),
            .above  (phAbove[gi])
         );
      end
   endgenerate

   // Host side register writes and the deferred thresholds
   always_comb
   begin
      sagPend_d = sagPend_q;
      zxPend_d  = zxPend_q;
      den_d     = den_q;
      mask_d    = mask_q;
      w1c       = '0;
      if (req.wr)
      begin
         if (req.addr == OFS_SAG)
            sagPend_d = req.wdata[SAMPLE_W-1:0];
         if (req.addr == OFS_ZX)
            zxPend_d = req.wdata[ZX_W-1:0];
         if (req.addr == OFS_MASK)
            mask_d = req.wdata[ST_W-1:0];
         if (req.addr == OFS_STATUS)
            w1c = req.wdata[ST_W-1:0];
         for (int i = 0; i < NUM_DEN; i++)
            if (req.addr == OFS_DEN0 + ADDR_W'(i * int'(OFS_STEP)))
               den_d.den[i] = req.wdata[DEN_W-1:0];
      end
      // Stays armed until the next reset
      armEvent = !armed_q && phase.valid && (|phAbove);
      armed_d  = armed_q | armEvent;
      // Detector keeps its old level until the input has been live
      sagAppl_d = armed_q ? sagPend_q : sagAppl_q;
      zxAppl_d  = armed_q ? zxPend_q : zxAppl_q;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         sagPend_q <= SAG_RST;
         sagAppl_q <= SAG_RST;
         zxPend_q  <= ZX_RST;
         zxAppl_q  <= ZX_RST;
         den_q     <= {NUM_DEN{DEN_RST}};
         mask_q    <= MASK_RST;
         armed_q   <= 1'b0;
      end
      else
      begin
         sagPend_q <= sagPend_d;
         sagAppl_q <= sagAppl_d;
         zxPend_q  <= zxPend_d;
         zxAppl_q  <= zxAppl_d;
         den_q     <= den_d;
         mask_q    <= mask_d;
         armed_q   <= armed_d;
      end
   end

   // Computation loop, rms pacing and interrupt status
   always_comb
   begin
      loopEnd   = loopCnt_q == LOOP_LAST;
      loopCnt_d = loopEnd ? '0 : loopCnt_q + CNT_W'(1);
      tick_d    = loopEnd;
      rms_d     = loopEnd ? rmsIn : rms_q;
      rmsHit    = req.rd && (req.addr >= OFS_RMS0) &&
                  (req.addr < OFS_RMS0 + ADDR_W'(NUM_RMS * 4));
      // Gap counts from the start of the previous rms read
      rmsTooSoon = rmsHit && (rmsGap_q < RMS_GAP);
      if (rmsHit)
         rmsGap_d = CNT_W'(1);
      else if (rmsGap_q < RMS_GAP)
         rmsGap_d = rmsGap_q + CNT_W'(1);
      else
         rmsGap_d = rmsGap_q;
      // A fresh corruption outranks the recovery at the loop end
      if (rmsTooSoon)
         corrupt_d = 1'b1;
      else if (loopEnd)
         corrupt_d = 1'b0;
      else
         corrupt_d = corrupt_q;
      events = '0;
      events[ST_LOOP]    = loopEnd;
      events[ST_CORRUPT] = rmsTooSoon;
      events[ST_ARMED]   = armEvent;
      // Set wins over a clear in the same cycle
      status_d = (status_q & ~w1c) | events;
   end

   // Read path, data one cycle after the strobe
   always_comb
   begin
      rdData_d = '0;
      if (req.rd)
      begin
         unique case (req.addr)
            OFS_SAG:    rdData_d[SAMPLE_W-1:0] = sagPend_q;
            OFS_ZX:     rdData_d[ZX_W-1:0]     = zxPend_q;
            OFS_STATUS: rdData_d[ST_W-1:0]     = status_q;
            OFS_MASK:   rdData_d[ST_W-1:0]     = mask_q;
            OFS_STATE:
            begin
               rdData_d[SS_ARMED]   = armed_q;
               rdData_d[SS_CORRUPT] = corrupt_q;
            end
            default:
            begin
               for (int i = 0; i < NUM_DEN; i++)
                  if (req.addr == OFS_DEN0 + ADDR_W'(i * int'(OFS_STEP)))
                     rdData_d[DEN_W-1:0] = den_q.den[i];
               for (int i = 0; i < NUM_RMS; i++)
                  if (req.addr == OFS_RMS0 + ADDR_W'(i * int'(OFS_STEP)))
                     // Too early a read returns the inverted result
                     rdData_d[SAMPLE_W-1:0] = rmsTooSoon ?
                        ~rms_q.val[i] : rms_q.val[i];
            end
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         loopCnt_q <= '0;
         rmsGap_q  <= RMS_GAP;
         corrupt_q <= 1'b0;
         tick_q    <= 1'b0;
         rms_q     <= '0;
         status_q  <= '0;
         rdData_q  <= '0;
      end
      else
      begin
         loopCnt_q <= loopCnt_d;
         rmsGap_q  <= rmsGap_d;
         corrupt_q <= corrupt_d;
         tick_q    <= tick_d;
         rms_q     <= rms_d;
         status_q  <= status_d;
         rdData_q  <= rdData_d;
      end
   end

   assign rdData             = rdData_q;
   assign sagLevelThreshold  = sagAppl_q;
   assign zeroCrossTimeout   = zxAppl_q;
   assign pulseOutputDen     = den_q;
   assign dataReadyInterrupt = tick_q;
   assign apparentCorrupt    = corrupt_q;
   assign firstInterruptPin  = |(status_q & mask_q);
endmodule // mra_top
`default_nettype wire

// >>> dv/mra_top_assertions.sv
// Assertions on the metering register access ports
`timescale 1ns/100ps
`default_nettype none
module mra_top_checker
   import mra_pkg::*;
#(
   parameter logic [SAMPLE_W-1:0] FULL_SCALE = 24'h40_0000
)
(
   input wire logic          mclk,               // Clock
   input wire logic          reset,              // Reset
   input wire mra_req_t      req,                // Request
   input wire mra_phase_t    phase,              // Samples
   input wire logic [23:0]   sagLevelThreshold,  // Sag in use
   input wire logic [15:0]   zeroCrossTimeout,   // Timeout in use
   input wire logic          dataReadyInterrupt, // Loop pulse
   input wire logic          apparentCorrupt     // Bad loop
);
   localparam int LVL = int'(FULL_SCALE) * 10 / 100;
   logic [11:0] loop_q;
   logic [11:0] gap_q;
   logic        arm_q;
   logic        rmsRd;
   logic        hit;
   assign rmsRd = req.rd && req.addr >= OFS_RMS0 && req.addr < 8'h30;
   always_comb
   begin
      hit = 1'b0;
      for (int i = 0; i < NUM_PH; i++)
         if ($signed(phase.volt[i]) > LVL || -$signed(phase.volt[i]) > LVL)
            hit = 1'b1;
   end
   // Gap saturates so the first rms read after reset is never too soon
   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         loop_q <= 12'hFFF;
         gap_q  <= 12'hFFF;
         arm_q  <= 1'b0;
      end
      else
      begin
         loop_q <= dataReadyInterrupt ? 12'h000 : loop_q + 12'h001;
         gap_q  <= rmsRd ? 12'h001 : gap_q + 12'(gap_q != 12'hFFF);
         arm_q  <= arm_q | (phase.valid & hit);
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   a_loop_period: assert property (
      dataReadyInterrupt |-> loop_q == 12'h4E1) else $error("loop short");
   a_loop_due: assert property (
      loop_q == 12'h4E1 |-> dataReadyInterrupt) else $error("loop long");
   a_sag_defer: assert property (
      !arm_q |-> sagLevelThreshold == SAG_RST) else $error("sag early");
   a_zx_defer: assert property (
      !arm_q |-> zeroCrossTimeout == ZX_RST) else $error("timeout early");
   a_rms_soon: assert property (
      rmsRd && gap_q < 12'hA5A |=> apparentCorrupt) else $error("no corrupt");
   a_corrupt_cause: assert property (
      $rose(apparentCorrupt) |-> $past(rmsRd) && $past(gap_q) < 12'hA5A)
      else $error("corrupt without cause");
   a_corrupt_recover: assert property (
      dataReadyInterrupt && !$past(rmsRd) |-> !apparentCorrupt)
      else $error("corrupt kept");
   a_corrupt_hold: assert property (
      $fell(apparentCorrupt) |-> dataReadyInterrupt) else $error("early clear");
endmodule // mra_top_checker
bind mra_top mra_top_checker #(.FULL_SCALE(FULL_SCALE)) u_mra_top_checker (
   .mclk(mclk), .reset(reset), .req(req), .phase(phase),
   .sagLevelThreshold(sagLevelThreshold), .zeroCrossTimeout(zeroCrossTimeout),
   .dataReadyInterrupt(dataReadyInterrupt), .apparentCorrupt(apparentCorrupt));
`default_nettype wire

// >>> dv/mra_host.sv
// Host model issuing register accesses to the meter
`timescale 1ns/100ps
`default_nettype none
module mra_host
   import mra_pkg::*;
(
   input wire logic        mclk,   // Clock
   input wire logic [31:0] rdData, // Read data
   input wire logic        dri,    // Data ready
   output var mra_req_t    req     // Request
);
   initial req = '0;
   task automatic acc(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge mclk);
      req <= {a, d, w, ~w};
      @(posedge mclk);
      req <= '0;
      #1 q = rdData;
   endtask
   // Repeats so a skipped update cannot survive
   task automatic wr8(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      repeat (8)
         acc(1'b1, a, d, q);
   endtask
   task automatic paced(input logic [7:0] a, output logic [31:0] q);
      repeat (3)
         @(posedge dri);
      acc(1'b0, a, '0, q);
   endtask
endmodule // mra_host
`default_nettype wire

// >>> dv/mra_top_bench.sv
// Self-checking bench of the metering register access block
`timescale 1ns/100ps
`default_nettype none
module mra_top_bench
   import mra_pkg::*;
;
   logic mclk, reset, dri, irq, corrupt;
   logic [31:0] rdData, q, v;
   logic [23:0] sag;
   logic [15:0] zx;
   mra_req_t req;
   mra_phase_t phase;
   mra_rms_t rmsIn;
   mra_den_t den;
   int seed = 41, miscompares = 0, samplesChecked = 0, cyc = 0, i;
   mra_top #(.FULL_SCALE(24'h00_03E8)) u_mra_top (.mclk(mclk), .reset(reset),
      .req(req), .rdData(rdData), .phase(phase), .rmsIn(rmsIn),
      .sagLevelThreshold(sag), .zeroCrossTimeout(zx), .pulseOutputDen(den),
      .dataReadyInterrupt(dri), .apparentCorrupt(corrupt),
      .firstInterruptPin(irq));
   mra_host u_mra_host (.mclk(mclk), .rdData(rdData), .dri(dri), .req(req));
   function automatic logic [31:0] rx(int n, logic b);
      return {8'h00, rmsIn.val[n] ^ {24{b}}};
   endfunction
   task automatic chk(input string n, input logic [31:0] s, e);
      samplesChecked++;
      if (s !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic testDone;
      if (miscompares == 0 && samplesChecked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic waitDri;
      @(posedge mclk) #1;
      repeat (1300)
         if (dri !== 1'b1)
            @(posedge mclk) #1;
   endtask
   task automatic chkIrq(input string n, input logic e);
      @(posedge mclk) #1;
      chk(n, 32'(irq), 32'(e));
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         miscompares++;
         testDone;
      end
   end
   initial
   begin
      reset = 1'b1;
      phase = '0;
      for (int n = 0; n < NUM_RMS; n++)
         rmsIn.val[n] = 24'($random(seed));
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      v = $random(seed);
      u_mra_host.acc(1'b1, OFS_SAG, {8'h00, v[23:0]}, q);
      u_mra_host.acc(1'b1, OFS_ZX, {16'h0000, v[15:0]}, q);
      u_mra_host.acc(1'b0, OFS_SAG, '0, q);
      chk("sagReadback", q, {8'h00, v[23:0]});
      u_mra_host.acc(1'b0, OFS_ZX, '0, q);
      chk("zxReadback", q, {16'h0000, v[15:0]});
      for (int n = 0; n < NUM_DEN; n++)
      begin
         u_mra_host.wr8(OFS_DEN0 + 8'(4 * n), {16'h0000, v[15:0] ^ 16'(n)});
         chk("den", {16'h0000, den.den[n]}, {16'h0000, v[15:0] ^ 16'(n)});
      end
      // Exactly at the arm level must not arm
      @(posedge mclk);
      phase <= {24'h00_0064, 24'hFF_FF9C, 24'h00_0000, 1'b1};
      repeat (3) @(posedge mclk);
      chk("sagHeld", {8'h00, sag}, 32'h0000_0000);
      chk("zxHeld", {16'h0000, zx}, 32'h0000_FFFF);
      phase <= {24'h00_0064, 24'hFF_FF9B, 24'h00_0000, 1'b1};
      repeat (3) @(posedge mclk);
      chk("sagUsed", {8'h00, sag}, {8'h00, v[23:0]});
      chk("zxUsed", {16'h0000, zx}, {16'h0000, v[15:0]});
      u_mra_host.acc(1'b1, OFS_MASK, 32'h0000_0001, q);
      waitDri;
      chkIrq("irqRaised", 1'b1);
      u_mra_host.acc(1'b1, OFS_MASK, 32'h0000_0000, q);
      chkIrq("irqMasked", 1'b0);
      u_mra_host.acc(1'b1, OFS_STATUS, 32'h0000_0007, q);
      u_mra_host.acc(1'b1, OFS_MASK, 32'h0000_0007, q);
      chkIrq("irqCleared", 1'b0);
      for (int r = 0; r < 2; r++)
      begin
         i = {$random(seed)} % NUM_RMS;
         u_mra_host.paced(OFS_RMS0 + 8'(4 * i), q);
         chk("rmsPaced", q, rx(i, 1'b0));
         i = (i + 1) % NUM_RMS;
         u_mra_host.acc(1'b0, OFS_RMS0 + 8'(4 * i), '0, q);
         chk("rmsSoon", q, rx(i, 1'b1));
         chk("apparentBad", 32'(corrupt), 32'h0000_0001);
         u_mra_host.acc(1'b0, OFS_STATUS, '0, q);
         chk("corruptFlag", 32'(q[ST_CORRUPT]), 32'h0000_0001);
         u_mra_host.acc(1'b0, OFS_STATE, '0, q);
         chk("stateBits", q, 32'h0000_0003);
         // Clear the flag so the next pass must set it again
         u_mra_host.acc(1'b1, OFS_STATUS, 32'h0000_0002, q);
         waitDri;
         chk("recovered", 32'(corrupt), 32'h0000_0000);
      end
      // Gap end points: one cycle short corrupts, the full gap does not
      u_mra_host.acc(1'b0, OFS_RMS0, '0, q);
      repeat (RMS_GAP_CYCLES - 3) @(posedge mclk);
      u_mra_host.acc(1'b0, OFS_RMS0, '0, q);
      chk("rmsEdgeSoon", q, rx(0, 1'b1));
      repeat (RMS_GAP_CYCLES - 2) @(posedge mclk);
      u_mra_host.acc(1'b0, OFS_RMS0, '0, q);
      chk("rmsEdgeOk", q, rx(0, 1'b0));
      chk("apparentOk", 32'(corrupt), 32'h0000_0000);
      u_mra_host.acc(1'b0, 8'h40, '0, q);
      chk("unmapped", q, 32'h0000_0000);
      testDone;
   end
endmodule // mra_top_bench
`default_nettype wire
